// ===== lcnr_pkg.sv
package lcnr_pkg;
    // register offsets (byte addresses)
    localparam logic [11:0] LCNR_LINK_CTRL_STATUS_OFF = 12'h0_0a0; // offset of own choosing
    localparam logic [11:0] LCNR_NP_REMAP_CTRL_OFF    = 12'h0_0e4;
    localparam logic [11:0] LCNR_NP_UPPER_BASE_OFF    = 12'h0_0e8;
    localparam int unsigned LCNR_ADDR_W               = 12;

    // link control / status field positions
    localparam int unsigned LCNR_ASPM_LSB      = 0;
    localparam int unsigned LCNR_RCB_BIT       = 3;
    localparam int unsigned LCNR_LINK_OFF_BIT  = 4;
    localparam int unsigned LCNR_RETRAIN_BIT   = 5;
    localparam int unsigned LCNR_REFCLK_BIT    = 6;
    localparam int unsigned LCNR_EXT_SYNC_BIT  = 7;
    localparam int unsigned LCNR_SPEED_LSB     = 16;
    localparam int unsigned LCNR_WIDTH_LSB     = 20;

    // fixed read values
    localparam logic [3:0] LCNR_SPEED_2G5      = 4'h1;
    localparam logic [5:0] LCNR_WIDTH_X1       = 6'h01;

    // aspm control codes
    localparam logic [1:0] LCNR_ASPM_OFF       = 2'h0;
    localparam logic [1:0] LCNR_ASPM_L0S       = 2'h1;

    // remap control field positions
    localparam int unsigned LCNR_REMAP_EN_BIT  = 3;
    localparam int unsigned LCNR_IO_SIZE_LSB   = 8;
    localparam int unsigned LCNR_LBASE_LSB     = 20;

    // reset values
    localparam logic [31:0] LCNR_RESET_WORD    = 32'h0000_0000;

    // exit latency codes, own choosing: {l1, l0s} per clocking mode
    localparam logic [2:0] LCNR_L0S_LAT_ASYNC  = 3'h6;
    localparam logic [2:0] LCNR_L0S_LAT_COMMON = 3'h4;
    localparam logic [2:0] LCNR_L1_LAT_ASYNC   = 3'h6;
    localparam logic [2:0] LCNR_L1_LAT_COMMON  = 3'h5;
endpackage

// ===== lcnr_exit_latency.sv
`timescale 1ns/1ns
module lcnr_exit_latency
    import lcnr_pkg::*;
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    // clocking mode
    input  wire logic       shared_refclk_in,
    // reported latencies
    output logic [2:0]      l0s_exit_lat_out,
    output logic [2:0]      l1_exit_lat_out
);
    // registered so the report follows the clock selection from flops
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            l0s_exit_lat_out <= LCNR_L0S_LAT_ASYNC;
            l1_exit_lat_out  <= LCNR_L1_LAT_ASYNC;
        end else begin
            l0s_exit_lat_out <= shared_refclk_in ? LCNR_L0S_LAT_COMMON
                                                 : LCNR_L0S_LAT_ASYNC;
            l1_exit_lat_out  <= shared_refclk_in ? LCNR_L1_LAT_COMMON
                                                 : LCNR_L1_LAT_ASYNC;
        end
    end
endmodule // lcnr_exit_latency

// ===== lcnr_regs.sv
`timescale 1ns/1ns
module lcnr_regs
    import lcnr_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_in,
    input  wire logic                   nrst_in,
    // register port
    input  wire logic [LCNR_ADDR_W-1:0] addr_in,
    input  wire logic [31:0]            wdata_in,
    input  wire logic                   wr_in,
    input  wire logic                   rd_in,
    output logic [31:0]                 rdata_out,
    // link control outputs
    output logic                        ext_sync_out,
    output logic                        shared_refclk_select_out,
    output logic                        completion_boundary_select_out,
    output logic                        l0s_entry_enable_out,
    output logic [2:0]                  l0s_exit_lat_out,
    output logic [2:0]                  l1_exit_lat_out,
    // remap outputs
    output logic                        np_window_remap_enable_out,
    output logic [4:0]                  io_discard_bits_out,
    output logic [11:0]                 np_window_lower_base_out,
    output logic [31:0]                 np_window_upper_base_out
);
    logic [1:0]  active_state_power_control_reg;
    logic [31:0] link_word;
    logic [31:0] remap_word;
    logic [31:0] rdata_next;

    // address decode helper, used for both writes and reads
    function automatic logic hit(input logic [LCNR_ADDR_W-1:0] a,
                                 input logic [LCNR_ADDR_W-1:0] off);
        return a == off;
    endfunction

    // link control writable bits; retrain, link-off and bit 2 have no flop
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ext_sync_out                   <= 1'b0;
            shared_refclk_select_out       <= 1'b0;
            completion_boundary_select_out <= 1'b0;
            active_state_power_control_reg <= LCNR_ASPM_OFF;
        end else if (wr_in && hit(addr_in, LCNR_LINK_CTRL_STATUS_OFF)) begin
            ext_sync_out                   <= wdata_in[LCNR_EXT_SYNC_BIT];
            shared_refclk_select_out       <= wdata_in[LCNR_REFCLK_BIT];
            completion_boundary_select_out <= wdata_in[LCNR_RCB_BIT];
            active_state_power_control_reg <= wdata_in[LCNR_ASPM_LSB +: 2];
        end
    end

    // reserved codes 10/11 are stored but enable nothing
    assign l0s_entry_enable_out = (active_state_power_control_reg == LCNR_ASPM_L0S);

    // remap control register
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            np_window_remap_enable_out <= 1'b0;
            io_discard_bits_out        <= 5'h00;
            np_window_lower_base_out   <= 12'h000;
        end else if (wr_in && hit(addr_in, LCNR_NP_REMAP_CTRL_OFF)) begin
            np_window_remap_enable_out <= wdata_in[LCNR_REMAP_EN_BIT];
            io_discard_bits_out        <= wdata_in[LCNR_IO_SIZE_LSB +: 5];
            np_window_lower_base_out   <= wdata_in[LCNR_LBASE_LSB +: 12];
        end
    end

    // upper base register
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            np_window_upper_base_out <= LCNR_RESET_WORD;
        end else if (wr_in && hit(addr_in, LCNR_NP_UPPER_BASE_OFF)) begin
            np_window_upper_base_out <= wdata_in;
        end
    end

    // read words; reserved bits are constant zero
    always_comb begin
        link_word = LCNR_RESET_WORD;
        link_word[LCNR_WIDTH_LSB +: 6]  = LCNR_WIDTH_X1;
        link_word[LCNR_SPEED_LSB +: 4]  = LCNR_SPEED_2G5;
        link_word[LCNR_EXT_SYNC_BIT]    = ext_sync_out;
        link_word[LCNR_REFCLK_BIT]      = shared_refclk_select_out;
        link_word[LCNR_RETRAIN_BIT]     = 1'b0;
        link_word[LCNR_LINK_OFF_BIT]    = 1'b0;
        link_word[LCNR_RCB_BIT]         = completion_boundary_select_out;
        link_word[2]                    = 1'b0;
        link_word[LCNR_ASPM_LSB +: 2]   = active_state_power_control_reg;
        remap_word = LCNR_RESET_WORD;
        remap_word[LCNR_LBASE_LSB +: 12]  = np_window_lower_base_out;
        remap_word[LCNR_IO_SIZE_LSB +: 5] = io_discard_bits_out;
        remap_word[LCNR_REMAP_EN_BIT]     = np_window_remap_enable_out;
        if (hit(addr_in, LCNR_LINK_CTRL_STATUS_OFF)) begin
            rdata_next = link_word;
        end else if (hit(addr_in, LCNR_NP_REMAP_CTRL_OFF)) begin
            rdata_next = remap_word;
        end else if (hit(addr_in, LCNR_NP_UPPER_BASE_OFF)) begin
            rdata_next = np_window_upper_base_out;
        end else begin
            rdata_next = LCNR_RESET_WORD; // unmapped reads zero
        end
    end

    // read data one cycle after strobe, zero otherwise
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rdata_out <= LCNR_RESET_WORD;
        end else if (rd_in) begin
            rdata_out <= rdata_next;
        end else begin
            rdata_out <= LCNR_RESET_WORD;
        end
    end

    // latency report tracks clock selection; retrain itself is left to software
    lcnr_exit_latency u_exit_latency (
        .clk_in           (clk_in),
        .nrst_in          (nrst_in),
        .shared_refclk_in (shared_refclk_select_out),
        .l0s_exit_lat_out (l0s_exit_lat_out),
        .l1_exit_lat_out  (l1_exit_lat_out)
    );
endmodule // lcnr_regs

// ===== lcnr_regs_assertions.sv
`timescale 1ns/1ns
module lcnr_regs_chk
    import lcnr_pkg::*;
(
    // bus side, grouped to keep the checker short
    input  wire logic                   clk_in, nrst_in, wr_in, rd_in,
    input  wire logic [LCNR_ADDR_W-1:0] addr_in,
    input  wire logic [31:0]            wdata_in, rdata_out, np_window_upper_base_out,
    // config side
    input  wire logic                   ext_sync_out, shared_refclk_select_out,
    input  wire logic                   completion_boundary_select_out, np_window_remap_enable_out,
    input  wire logic [2:0]             l0s_exit_lat_out, l1_exit_lat_out,
    input  wire logic [4:0]             io_discard_bits_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // decoded accesses
    wire w_lk = wr_in && addr_in == LCNR_LINK_CTRL_STATUS_OFF;
    wire w_np = wr_in && addr_in == LCNR_NP_REMAP_CTRL_OFF;
    wire r_lk = rd_in && addr_in == LCNR_LINK_CTRL_STATUS_OFF;
    a_sync_write: assert property (w_lk |=> ext_sync_out == $past(wdata_in[7]))
        else $error("sync bit not taken");
    a_clk_select: assert property (w_lk |=> shared_refclk_select_out == $past(wdata_in[6]))
        else $error("clock select not taken");
    a_rcb_write: assert property (w_lk |=> completion_boundary_select_out == $past(wdata_in[3]))
        else $error("boundary bit not taken");
    // latency flops lag the select by one cycle, so compare against last cycle's select
    a_lat_follow: assert property ({l1_exit_lat_out, l0s_exit_lat_out} ==
        ($past(shared_refclk_select_out) ?
        {LCNR_L1_LAT_COMMON, LCNR_L0S_LAT_COMMON} : {LCNR_L1_LAT_ASYNC, LCNR_L0S_LAT_ASYNC}))
        else $error("latency mismatch");
    a_read_fixed: assert property (r_lk |=> rdata_out[25:16] == {LCNR_WIDTH_X1, LCNR_SPEED_2G5} &&
        rdata_out[5:2] == {2'h0, completion_boundary_select_out, 1'h0})
        else $error("fixed link bits wrong");
    a_remap_en: assert property (w_np |=> np_window_remap_enable_out == $past(wdata_in[3]))
        else $error("remap enable not taken");
    a_io_size: assert property (w_np |=> io_discard_bits_out == $past(wdata_in[12:8]))
        else $error("discard count not taken");
    a_upper_base: assert property (wr_in && addr_in == LCNR_NP_UPPER_BASE_OFF |=>
        np_window_upper_base_out == $past(wdata_in)) else $error("upper base not taken");
endmodule // lcnr_regs_chk

// ===== tb.sv
`timescale 1ns/1ns
module tb;
    import lcnr_pkg::*;
    // stimulus and observed signals
    logic        clk_in = 0, nrst_in = 0, wr_in = 0, rd_in = 0;
    logic [11:0] addr_in = '0, io_a;
    logic [31:0] wdata_in = '0, rdata_out, np_window_upper_base_out, d;
    logic        ext_sync_out, shared_refclk_select_out, completion_boundary_select_out;
    logic        l0s_entry_enable_out, np_window_remap_enable_out;
    logic [2:0]  l0s_exit_lat_out, l1_exit_lat_out;
    logic [4:0]  io_discard_bits_out;
    logic [11:0] np_window_lower_base_out;
    int          error_cnt = 0, n_tests = 0, cyc = 0;
    lcnr_regs uut (.clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .ext_sync_out, .shared_refclk_select_out, .completion_boundary_select_out,
        .l0s_entry_enable_out, .l0s_exit_lat_out, .l1_exit_lat_out, .np_window_remap_enable_out,
        .io_discard_bits_out, .np_window_lower_base_out, .np_window_upper_base_out);
    initial forever #5 clk_in = ~clk_in;
    // hang guard, far beyond the ~700 cycles the run needs
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] v);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'h1;
        @(posedge clk_in);
        wr_in <= 1'h0;
    endtask
    // data only stands in the cycle after the strobe, so sample just past that edge
    task automatic rd(string nm, logic [11:0] a, logic [31:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'h1;
        @(posedge clk_in);
        rd_in <= 1'h0;
        #1;
        chk(nm, rdata_out, e);
    endtask
    // link word as software should see it
    function automatic logic [31:0] lk(logic [31:0] v);
        return {6'h00, LCNR_WIDTH_X1, LCNR_SPEED_2G5, 8'h00, v[7:6], 2'h0, v[3], 1'h0, v[1:0]};
    endfunction
    initial begin
        void'($urandom(32'hcdb2));
        io_a = 12'h0_0ec;
        repeat (3) @(posedge clk_in);
        nrst_in <= 1'h1;
        for (int i = 0; i < 40; i++) begin
            if (i == 20) begin
                nrst_in <= 1'h0;
                @(posedge clk_in);
                nrst_in <= 1'h1;
            end
            if (i % 20 == 0) rd("link rst", LCNR_LINK_CTRL_STATUS_OFF, lk(LCNR_RESET_WORD));
            if (i % 20 == 0) rd("remap rst", LCNR_NP_REMAP_CTRL_OFF, LCNR_RESET_WORD);
            // corners first: all zeros, then all ones above the aspm field; aspm code cycles through 00..11
            d = (i < 2) ? {32{i[0]}} : $urandom;
            d[1:0] = 2'(i);
            wr(LCNR_LINK_CTRL_STATUS_OFF, d);
            wr(LCNR_NP_REMAP_CTRL_OFF, d);
            wr(LCNR_NP_UPPER_BASE_OFF, ~d);
            wr(io_a, d);
            rd("link", LCNR_LINK_CTRL_STATUS_OFF, lk(d));
            rd("remap", LCNR_NP_REMAP_CTRL_OFF, d & 32'hfff0_1f08);
            rd("base", LCNR_NP_UPPER_BASE_OFF, ~d);
            rd("unmapped", io_a, 32'h0000_0000);
            chk("aspm", {31'h0, l0s_entry_enable_out}, {31'h0, d[1:0] == LCNR_ASPM_L0S});
            chk("lat", {26'h0, l1_exit_lat_out, l0s_exit_lat_out}, {26'h0, d[6] ?
                {LCNR_L1_LAT_COMMON, LCNR_L0S_LAT_COMMON} : {LCNR_L1_LAT_ASYNC, LCNR_L0S_LAT_ASYNC}});
            chk("cfg", {11'h0, ext_sync_out, shared_refclk_select_out, completion_boundary_select_out,
                np_window_remap_enable_out, io_discard_bits_out, np_window_lower_base_out},
                {11'h0, d[7:6], d[3], d[3], d[12:8], d[31:20]});
            chk("upper", np_window_upper_base_out, ~d);
        end
        report_and_stop();
    end
endmodule // tb
bind lcnr_regs lcnr_regs_chk u_chk (.clk_in, .nrst_in, .wr_in, .rd_in, .addr_in, .wdata_in,
    .rdata_out, .np_window_upper_base_out, .ext_sync_out, .shared_refclk_select_out,
    .completion_boundary_select_out, .np_window_remap_enable_out, .l0s_exit_lat_out,
    .l1_exit_lat_out, .io_discard_bits_out);
